/* File: logic/bert_pkg.sv */
// Constants for the bit-error tester counters and error insertion
// Overview of operation
// - The 32-bit bit count is read as four bytes, lowest byte holding bit 0.
// - The 24-bit error count is read as three bytes, lowest byte holding bit 0.
// - Receive unframed bit 6 set lets the frame-bit position reach the checker.
// - Transmit unframed bit 3 set lets the generator fill the frame-bit slot.
// - A rising edge of the byte-align bit realigns the generator to bytes.
// - Direction 0 uses the line pins, direction 1 uses the backplane pins.
// - Checking, counting, transmit bits, insertion and pin selects run only while enable bit 0 of the path control is set.
// - A rising edge of commit bit 7 loads the error budget on the next clock.
// - Constant mode with a nonzero rate inserts forever and ignores budget.
// - Rate code 0 inserts nothing; codes 1 to 15 give 1 in 2^(code+3) bits.
// - The 10-bit budget sits in the low byte and bits 1:0 of the high byte.
// - The errors still to insert are readable as a 10-bit two-byte value.
// - A rising edge of the latch bit copies and clears the running counts.
package bert_pkg;
	localparam logic [7:0] ADDR_BIT_COUNT_BYTE0   = 8'he3;
	localparam logic [7:0] ADDR_BIT_COUNT_BYTE1   = 8'he4;
	localparam logic [7:0] ADDR_BIT_COUNT_BYTE2   = 8'he5;
	localparam logic [7:0] ADDR_BIT_COUNT_BYTE3   = 8'he6;
	localparam logic [7:0] ADDR_ERROR_COUNT_BYTE0 = 8'he7;
	localparam logic [7:0] ADDR_ERROR_COUNT_BYTE1 = 8'he8;
	localparam logic [7:0] ADDR_ERROR_COUNT_BYTE2 = 8'he9;
	localparam logic [7:0] ADDR_TEST_PATH_CONTROL = 8'hea;
	localparam logic [7:0] ADDR_INSERTION_CONTROL = 8'heb;
	localparam logic [7:0] ADDR_ERROR_BUDGET_LOW  = 8'hec;
	localparam logic [7:0] ADDR_ERROR_BUDGET_HIGH = 8'hed;
	localparam logic [7:0] ADDR_ERRORS_LEFT_LOW   = 8'hee;
	localparam logic [7:0] ADDR_ERRORS_LEFT_HIGH  = 8'hef;
	localparam logic [7:0] ADDR_LATCH_CONTROL     = 8'he0;
	// Path control fields
	localparam int POS_TESTER_ENABLE      = 0;
	localparam int POS_TEST_DIRECTION     = 1;
	localparam int POS_TX_UNFRAMED        = 3;
	localparam int POS_TX_BYTE_ALIGN      = 4;
	localparam int POS_RX_UNFRAMED        = 6;
	localparam logic [7:0] PATH_MASK      = 8'h5b;
	// Insertion control, latch control and other fields
	localparam int POS_COMMIT             = 7;
	localparam int POS_CONSTANT           = 4;
	localparam logic [7:0] INSERT_MASK    = 8'h9f;
	localparam int POS_COUNTER_LATCH      = 1;
	localparam logic [7:0] LATCH_MASK     = 8'h02;
	localparam logic [7:0] BUDGET_HI_MASK = 8'h03;
	localparam logic [7:0] RESET_BYTE     = 8'h00;
	localparam int RATE_BASE_SHIFT        = 3;
	localparam int RATE_WIDTH             = 18;
endpackage

/* File: logic/bert_counters_error_insert.sv */
// Bit-error tester counters, path control and error insertion engine
//
// Chosen here: the plain strobed port.
module bert_counters_error_insert
	import bert_pkg::*;
#(
	parameter int BIT_W  = 32,
	parameter int ERR_W  = 24,
	parameter int BUD_W  = 10
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// Generator and formatter side
	input  wire logic       tx_bit_strobe,
	input  wire logic       tx_fbit_slot,
	input  wire logic       tx_pattern_bit,
	output logic            tx_byte_align_pulse,
	output logic            tx_source_fbit,
	output logic            tx_data_valid,
	output logic            tx_data,
	output logic            line_tx_sel,
	output logic            backplane_tx_sel,
	// Receive checker side
	input  wire logic       line_rx_strobe,
	input  wire logic       backplane_rx_strobe,
	input  wire logic       rx_fbit_slot,
	input  wire logic       rx_bit_error,
	output logic            rx_check_en
);
	import bert_pkg::*;

	typedef struct packed {
		logic [7:0]       path;
		logic [7:0]       insert;
		logic [7:0]       latch;
		logic [7:0]       bud_lo;
		logic [7:0]       bud_hi;
		logic [BIT_W-1:0] bit_run;
		logic [ERR_W-1:0] err_run;
		logic [BIT_W-1:0] bit_shown;
		logic [ERR_W-1:0] err_shown;
		logic [BUD_W-1:0] left;
		logic [RATE_WIDTH-1:0] rate_cnt;
		logic [7:0]       rdata;
		logic             align;
		logic             txd;
		logic             txv;
	} state_t;

	state_t s_r, s_nxt;

	logic enable, dir, rx_strobe, rx_take, tx_take, ins_now, rate_hit;
	logic constant_mode;
	logic [3:0] rate;
	logic [RATE_WIDTH-1:0] rate_last;

	always_comb begin
		enable        = s_r.path[POS_TESTER_ENABLE];
		dir           = s_r.path[POS_TEST_DIRECTION];
		rate          = s_r.insert[3:0];
		constant_mode = s_r.insert[POS_CONSTANT];
		// Rate code k gives one error per 2^(k+3) bits
		rate_last = RATE_WIDTH'((32'd1 << (32'(rate) + RATE_BASE_SHIFT)) - 1);
		rx_strobe = dir ? backplane_rx_strobe : line_rx_strobe;
		// Framed receive skips the frame-bit slot
		rx_take   = enable && rx_strobe &&
			(s_r.path[POS_RX_UNFRAMED] || !rx_fbit_slot);
		tx_take   = enable && tx_bit_strobe &&
			(s_r.path[POS_TX_UNFRAMED] || !tx_fbit_slot);
		rate_hit  = (rate != 4'h0) && (s_r.rate_cnt == rate_last);
		ins_now   = tx_take && rate_hit &&
			(constant_mode || (s_r.left != '0));
	end

	always_comb begin
		s_nxt       = s_r;
		s_nxt.align = 1'b0;
		s_nxt.txv   = tx_take;
		if (tx_take)
			s_nxt.txd = tx_pattern_bit ^ ins_now;
		if (wr) begin
			unique case (addr)
			ADDR_TEST_PATH_CONTROL: begin
				s_nxt.path = wdata & PATH_MASK;
				// Rising edge realigns the generator
				s_nxt.align = wdata[POS_TX_BYTE_ALIGN] &&
					!s_r.path[POS_TX_BYTE_ALIGN];
			end
			ADDR_INSERTION_CONTROL: s_nxt.insert = wdata & INSERT_MASK;
			ADDR_LATCH_CONTROL:     s_nxt.latch  = wdata & LATCH_MASK;
			ADDR_ERROR_BUDGET_LOW:  s_nxt.bud_lo = wdata;
			ADDR_ERROR_BUDGET_HIGH: s_nxt.bud_hi = wdata & BUDGET_HI_MASK;
			default: ;
			endcase
		end
		// Rate divider counts only taken transmit bits
		if (!enable || rate == 4'h0)
			s_nxt.rate_cnt = '0;
		else if (tx_take)
			s_nxt.rate_cnt = rate_hit ? '0 : s_r.rate_cnt + 1'b1;
		if (ins_now && !constant_mode)
			s_nxt.left = s_r.left - 1'b1;
		// Commit loads budget one clock after the rising edge write
		if (s_r.insert[POS_COMMIT] && !s_r.latch[7] )
			s_nxt.left = {s_r.bud_hi[1:0], s_r.bud_lo};
		s_nxt.latch[7] = s_r.insert[POS_COMMIT];
		if (rx_take) begin
			s_nxt.bit_run = s_r.bit_run + 1'b1;
			if (rx_bit_error)
				s_nxt.err_run = s_r.err_run + 1'b1;
		end
		// Latch edge copies counts and restarts the period
		if (wr && addr == ADDR_LATCH_CONTROL &&
			wdata[POS_COUNTER_LATCH] && !s_r.latch[POS_COUNTER_LATCH]) begin
			s_nxt.bit_shown = s_r.bit_run;
			s_nxt.err_shown = s_r.err_run;
			s_nxt.bit_run   = '0;
			s_nxt.err_run   = '0;
		end
		s_nxt.rdata = RESET_BYTE;
		if (rd) begin
			unique case (addr)
			ADDR_BIT_COUNT_BYTE0:   s_nxt.rdata = s_r.bit_shown[7:0];
			ADDR_BIT_COUNT_BYTE1:   s_nxt.rdata = s_r.bit_shown[15:8];
			ADDR_BIT_COUNT_BYTE2:   s_nxt.rdata = s_r.bit_shown[23:16];
			ADDR_BIT_COUNT_BYTE3:   s_nxt.rdata = s_r.bit_shown[31:24];
			ADDR_ERROR_COUNT_BYTE0: s_nxt.rdata = s_r.err_shown[7:0];
			ADDR_ERROR_COUNT_BYTE1: s_nxt.rdata = s_r.err_shown[15:8];
			ADDR_ERROR_COUNT_BYTE2: s_nxt.rdata = s_r.err_shown[23:16];
			ADDR_TEST_PATH_CONTROL: s_nxt.rdata = s_r.path;
			ADDR_INSERTION_CONTROL: s_nxt.rdata = s_r.insert;
			ADDR_LATCH_CONTROL:     s_nxt.rdata = s_r.latch & LATCH_MASK;
			ADDR_ERROR_BUDGET_LOW:  s_nxt.rdata = s_r.bud_lo;
			ADDR_ERROR_BUDGET_HIGH: s_nxt.rdata = s_r.bud_hi;
			ADDR_ERRORS_LEFT_LOW:   s_nxt.rdata = s_r.left[7:0];
			ADDR_ERRORS_LEFT_HIGH:  s_nxt.rdata = {6'h00, s_r.left[9:8]};
			default:                s_nxt.rdata = RESET_BYTE;
			endcase
		end
		if (srst)
			s_nxt = '0;
	end

	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	assign rdata               = s_r.rdata;
	assign tx_byte_align_pulse = s_r.align;
	assign tx_data             = s_r.txd;
	assign tx_data_valid       = s_r.txv;
	assign tx_source_fbit      = enable && s_r.path[POS_TX_UNFRAMED];
	assign line_tx_sel         = enable && !dir;
	assign backplane_tx_sel    = enable && dir;
	assign rx_check_en         = rx_take;

	property p_align;
		@(posedge clk) disable iff (srst)
		wr && addr == ADDR_TEST_PATH_CONTROL && wdata[4] && !s_r.path[4]
			|=> tx_byte_align_pulse;
	endproperty
	a_align: assert property (p_align) else $error("align lost");

	property p_commit;
		@(posedge clk) disable iff (srst)
		wr && addr == ADDR_INSERTION_CONTROL && wdata[7] && !s_r.insert[7]
			|=> ##1 s_r.left == $past({s_r.bud_hi[1:0], s_r.bud_lo});
	endproperty
	a_commit: assert property (p_commit) else $error("commit bad");

	property p_disabled;
		@(posedge clk) disable iff (srst)
		!enable |-> !rx_check_en && !line_tx_sel && !backplane_tx_sel;
	endproperty
	a_disabled: assert property (p_disabled) else $error("tester on");

	property p_framed_rx;
		@(posedge clk) disable iff (srst)
		rx_fbit_slot && !s_r.path[6] |-> !rx_check_en;
	endproperty
	a_framed_rx: assert property (p_framed_rx) else $error("fbit fed");

	property p_framed_tx;
		@(posedge clk) disable iff (srst)
		tx_fbit_slot && !s_r.path[3] && tx_bit_strobe |=> !tx_data_valid;
	endproperty
	a_framed_tx: assert property (p_framed_tx) else $error("fbit sourced");

	property p_stop_zero;
		@(posedge clk) disable iff (srst)
		!constant_mode && s_r.left == 0 |-> !ins_now;
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("over budget");

	property p_no_rate;
		@(posedge clk) disable iff (srst)
		rate == 4'h0 |-> !ins_now;
	endproperty
	a_no_rate: assert property (p_no_rate) else $error("rate zero ins");

	property p_decrement;
		@(posedge clk) disable iff (srst)
		ins_now && !constant_mode && !(s_r.insert[7] && !s_r.latch[7])
			|=> s_r.left == $past(s_r.left) - 1'b1;
	endproperty
	a_decrement: assert property (p_decrement) else $error("no decrement");

	property p_latch;
		@(posedge clk) disable iff (srst)
		wr && addr == ADDR_LATCH_CONTROL && wdata[1] && !s_r.latch[1]
			|=> s_r.bit_run == 0 && s_r.bit_shown == $past(s_r.bit_run);
	endproperty
	a_latch: assert property (p_latch) else $error("latch bad");

	property p_rdata_idle;
		@(posedge clk) disable iff (srst)
		!rd |=> rdata == RESET_BYTE;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("rdata");

	property p_rd_b0;
		@(posedge clk) disable iff (srst)
		rd && addr == ADDR_BIT_COUNT_BYTE0
			|=> rdata == $past(s_r.bit_shown[7:0]);
	endproperty
	a_rd_b0: assert property (p_rd_b0) else $error("b0");

	property p_rd_b1;
		@(posedge clk) disable iff (srst)
		rd && addr == ADDR_BIT_COUNT_BYTE1
			|=> rdata == $past(s_r.bit_shown[15:8]);
	endproperty
	a_rd_b1: assert property (p_rd_b1) else $error("b1");

	property p_rd_b3;
		@(posedge clk) disable iff (srst)
		rd && addr == ADDR_BIT_COUNT_BYTE3
			|=> rdata == $past(s_r.bit_shown[31:24]);
	endproperty
	a_rd_b3: assert property (p_rd_b3) else $error("b3");

	property p_rd_e0;
		@(posedge clk) disable iff (srst)
		rd && addr == ADDR_ERROR_COUNT_BYTE0
			|=> rdata == $past(s_r.err_shown[7:0]);
	endproperty
	a_rd_e0: assert property (p_rd_e0) else $error("e0");

	property p_rd_e1;
		@(posedge clk) disable iff (srst)
		rd && addr == ADDR_ERROR_COUNT_BYTE1
			|=> rdata == $past(s_r.err_shown[15:8]);
	endproperty
	a_rd_e1: assert property (p_rd_e1) else $error("e1");

	property p_rd_e2;
		@(posedge clk) disable iff (srst)
		rd && addr == ADDR_ERROR_COUNT_BYTE2
			|=> rdata == $past(s_r.err_shown[23:16]);
	endproperty
	a_rd_e2: assert property (p_rd_e2) else $error("e2");

	property p_rd_left_lo;
		@(posedge clk) disable iff (srst)
		rd && addr == ADDR_ERRORS_LEFT_LOW
			|=> rdata == $past(s_r.left[7:0]);
	endproperty
	a_rd_left_lo: assert property (p_rd_left_lo) else $error("ll");

	property p_rd_left_hi;
		@(posedge clk) disable iff (srst)
		rd && addr == ADDR_ERRORS_LEFT_HIGH
			|=> rdata == {6'h00, $past(s_r.left[9:8])};
	endproperty
	a_rd_left_hi: assert property (p_rd_left_hi) else $error("lh");

	property p_rd_bud_hi;
		@(posedge clk) disable iff (srst)
		rd && addr == ADDR_ERROR_BUDGET_HIGH |=> rdata[7:2] == 6'h00;
	endproperty
	a_rd_bud_hi: assert property (p_rd_bud_hi) else $error("bh");

	property p_bud_lo;
		@(posedge clk) disable iff (srst)
		wr && addr == ADDR_ERROR_BUDGET_LOW
			|=> s_r.bud_lo == $past(wdata);
	endproperty
	a_bud_lo: assert property (p_bud_lo) else $error("bl");

	property p_path_wr;
		@(posedge clk) disable iff (srst)
		wr && addr == ADDR_TEST_PATH_CONTROL
			|=> s_r.path == ($past(wdata) & PATH_MASK);
	endproperty
	a_path_wr: assert property (p_path_wr) else $error("path");

	property p_sel_excl;
		@(posedge clk) disable iff (srst)
		!(line_tx_sel && backplane_tx_sel);
	endproperty
	a_sel_excl: assert property (p_sel_excl) else $error("two sel");

	property p_rx_bp;
		@(posedge clk) disable iff (srst)
		enable && dir && !backplane_rx_strobe |-> !rx_check_en;
	endproperty
	a_rx_bp: assert property (p_rx_bp) else $error("rx bp");

	property p_rx_line;
		@(posedge clk) disable iff (srst)
		enable && !dir && !line_rx_strobe |-> !rx_check_en;
	endproperty
	a_rx_line: assert property (p_rx_line) else $error("rx line");

	property p_bit_inc;
		@(posedge clk) disable iff (srst)
		rx_check_en && !wr
			|=> s_r.bit_run == $past(s_r.bit_run) + 1'b1;
	endproperty
	a_bit_inc: assert property (p_bit_inc) else $error("bit inc");

	property p_err_inc;
		@(posedge clk) disable iff (srst)
		rx_check_en && rx_bit_error && !wr
			|=> s_r.err_run == $past(s_r.err_run) + 1'b1;
	endproperty
	a_err_inc: assert property (p_err_inc) else $error("err inc");

	property p_latch_err;
		@(posedge clk) disable iff (srst)
		wr && addr == ADDR_LATCH_CONTROL && wdata[1] && !s_r.latch[1]
			|=> s_r.err_run == 0 && s_r.err_shown == $past(s_r.err_run);
	endproperty
	a_latch_err: assert property (p_latch_err) else $error("lat e");

	property p_shown_hold;
		@(posedge clk) disable iff (srst)
		!wr |=> s_r.bit_shown == $past(s_r.bit_shown)
			&& s_r.err_shown == $past(s_r.err_shown);
	endproperty
	a_shown_hold: assert property (p_shown_hold) else $error("sh");

	property p_align_once;
		@(posedge clk) disable iff (srst)
		tx_byte_align_pulse |=> !tx_byte_align_pulse;
	endproperty
	a_align_once: assert property (p_align_once) else $error("al");

	property p_const_hold;
		@(posedge clk) disable iff (srst)
		constant_mode && !(s_r.insert[7] && !s_r.latch[7])
			|=> s_r.left == $past(s_r.left);
	endproperty
	a_const_hold: assert property (p_const_hold) else $error("ch");

	property p_tx_valid;
		@(posedge clk) disable iff (srst)
		tx_bit_strobe && enable && (s_r.path[3] || !tx_fbit_slot)
			|=> tx_data_valid;
	endproperty
	a_tx_valid: assert property (p_tx_valid) else $error("tv");

	property p_tx_clean;
		@(posedge clk) disable iff (srst)
		tx_take && !ins_now |=> tx_data == $past(tx_pattern_bit);
	endproperty
	a_tx_clean: assert property (p_tx_clean) else $error("tc");

	property p_tx_flip;
		@(posedge clk) disable iff (srst)
		ins_now |=> tx_data == !$past(tx_pattern_bit);
	endproperty
	a_tx_flip: assert property (p_tx_flip) else $error("tf");

	c_insert: cover property (@(posedge clk) ins_now);
	c_commit: cover property (@(posedge clk) s_r.insert[7] && !s_r.latch[7]);
	c_latch:  cover property (@(posedge clk) s_r.latch[1] && !srst);
	c_const:  cover property (@(posedge clk) ins_now && constant_mode);
	c_align:  cover property (@(posedge clk) tx_byte_align_pulse);
endmodule

/* File: testbench/bert_far_side.sv */
// Far-side stand-in: transmit formatter and receive path, random driven
module bert_far_side (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Stimulus from the bench
	input  wire logic       run,
	input  wire logic [7:0] rnd,
	// Toward the block
	output logic            tx_bit_strobe,
	output logic            tx_fbit_slot,
	output logic            tx_pattern_bit,
	output logic            line_rx_strobe,
	output logic            backplane_rx_strobe,
	output logic            rx_fbit_slot,
	output logic            rx_bit_error
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge clk) begin
		if (srst) begin
			{tx_pattern_bit, rx_fbit_slot, rx_bit_error} <= 3'h0;
		end else begin
			// Idle data toggles so a stale bit is never read as fresh
			tx_pattern_bit <= run ? rnd[2] : !tx_pattern_bit;
			rx_fbit_slot   <= run ? (rnd[5] & rnd[6]) : !rx_fbit_slot;
			rx_bit_error   <= run ? rnd[7] : !rx_bit_error;
		end
		tx_bit_strobe       <= run && !srst && rnd[1:0] != 2'h0;
		line_rx_strobe      <= run && !srst && rnd[3];
		backplane_rx_strobe <= run && !srst && rnd[4];
		tx_fbit_slot        <= run && !srst && rnd[0] && rnd[5];
	end
endmodule

/* File: testbench/bert_counters_error_insert_bench.sv */
// Bench for the tester counters, path control and error insertion
module bert_counters_error_insert_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import bert_pkg::*;
	logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rnd = 8'h00, rdata, rv;
	logic [7:0]  path_m, ins_m;
	logic [7:0]  modes [4] = '{8'h49, 8'h4b, 8'h09, 8'h00};
	logic [31:0] seed = 32'h26ff, snap_b;
	logic [23:0] snap_e;
	logic        tx_bit_strobe, tx_fbit_slot, tx_pattern_bit, line_rx_strobe;
	logic        backplane_rx_strobe, rx_fbit_slot, rx_bit_error, rx_check_en;
	logic        tx_byte_align_pulse, tx_source_fbit, tx_data_valid, tx_data;
	logic        line_tx_sel, backplane_tx_sel, exp_rx, lc_m, al_pend;
	logic        prev_take, prev_pat;
	int          fail_count, n_compared, cyc, nflip, gap, nbit, nerr;

	bert_counters_error_insert DUT (.clk, .srst, .addr, .wdata, .wr, .rd,
		.rdata, .tx_bit_strobe, .tx_fbit_slot, .tx_pattern_bit,
		.tx_byte_align_pulse, .tx_source_fbit, .tx_data_valid, .tx_data,
		.line_tx_sel, .backplane_tx_sel, .line_rx_strobe,
		.backplane_rx_strobe, .rx_fbit_slot, .rx_bit_error, .rx_check_en);
	bert_far_side far (.clk, .srst, .run, .rnd, .tx_bit_strobe,
		.tx_fbit_slot, .tx_pattern_bit, .line_rx_strobe,
		.backplane_rx_strobe, .rx_fbit_slot, .rx_bit_error);

	always #5 clk = ~clk;

	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wreg(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a; wdata <= d; wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(logic [7:0] a);
		@(posedge clk);
		addr <= a; rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask

	// Quiet link first, so the latched counts cannot move under the reads
	task automatic run_and_latch(int n);
		run <= 1'b1;
		repeat (n) @(posedge clk);
		run <= 1'b0;
		repeat (3) @(posedge clk);
		wreg(ADDR_LATCH_CONTROL, 8'h02);
		wreg(ADDR_LATCH_CONTROL, 8'h00);
		for (int i = 0; i < 7; i++) begin
			rreg(ADDR_BIT_COUNT_BYTE0 + i[7:0]);
			chk("count byte", rv, i < 4 ? snap_b[8*i +: 8] : snap_e[8*(i-4) +: 8]);
		end
	endtask

	// Reference model, compared every cycle
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			final_report();
		end
		seed = xs(seed);
		rnd <= seed[7:0];
		exp_rx = path_m[0] && (path_m[1] ? backplane_rx_strobe : line_rx_strobe)
			&& (!rx_fbit_slot || path_m[6]);
		if (srst) begin
			{path_m, ins_m, lc_m, al_pend, prev_take} = '0;
			{nbit, nerr, nflip, gap} = '0;
			{snap_b, snap_e} = '0;
		end else begin
			chk("tx_data_valid", tx_data_valid, prev_take);
			if (prev_take && (tx_data ^ prev_pat)) begin
				if (gap > 0)
					chk("error spacing", gap, 1 << (ins_m[3:0] + 3));
				nflip++;
				gap = 0;
			end
			chk("line_tx_sel", line_tx_sel, path_m[0] & !path_m[1]);
			chk("backplane_tx_sel", backplane_tx_sel, path_m[0] & path_m[1]);
			chk("tx_source_fbit", tx_source_fbit, path_m[0] & path_m[3]);
			chk("rx_check_en", rx_check_en, exp_rx);
			chk("align pulse", tx_byte_align_pulse, al_pend);
			nbit += exp_rx;
			nerr += exp_rx & rx_bit_error;
			al_pend = wr && addr == ADDR_TEST_PATH_CONTROL && wdata[4] && !path_m[4];
			prev_take = tx_bit_strobe && path_m[0] &&
				(path_m[3] || !tx_fbit_slot);
			prev_pat = tx_pattern_bit;
			if (prev_take && gap >= 0)
				gap++;
			if (wr && addr == ADDR_TEST_PATH_CONTROL)
				path_m = wdata & PATH_MASK;
			if (wr && addr == ADDR_INSERTION_CONTROL) begin
				ins_m = wdata;
				gap = -1;
			end
			if (wr && addr == ADDR_LATCH_CONTROL) begin
				if (wdata[1] && !lc_m) begin
					snap_b = nbit;
					snap_e = nerr[23:0];
					{nbit, nerr} = '0;
				end
				lc_m = wdata[1];
			end
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		for (int a = 'he3; a <= 'hf0; a++) begin
			rreg(a[7:0]);
			chk("reset value", rv, 8'h00);
		end
		wreg(8'hf0, 8'hff);
		rreg(8'hf0);
		chk("unmapped", rv, 8'h00);
		wreg(ADDR_TEST_PATH_CONTROL, 8'hff);
		rreg(ADDR_TEST_PATH_CONTROL);
		chk("path readback", rv, PATH_MASK);
		for (int i = 0; i < 4; i++) begin
			wreg(ADDR_TEST_PATH_CONTROL, modes[i]);
			run_and_latch(150);
		end
		wreg(ADDR_ERROR_BUDGET_LOW, 8'hff);
		wreg(ADDR_ERROR_BUDGET_HIGH, 8'hfe);
		rreg(ADDR_ERROR_BUDGET_HIGH);
		chk("budget high", rv, 8'h02);
		wreg(ADDR_INSERTION_CONTROL, 8'h80);
		wreg(ADDR_INSERTION_CONTROL, 8'h00);
		rreg(ADDR_ERRORS_LEFT_LOW);
		chk("left low", rv, 8'hff);
		rreg(ADDR_ERRORS_LEFT_HIGH);
		chk("left high", rv, 8'h02);
		wreg(ADDR_TEST_PATH_CONTROL, 8'h41);
		wreg(ADDR_ERROR_BUDGET_LOW, 8'h03);
		wreg(ADDR_ERROR_BUDGET_HIGH, 8'h00);
		wreg(ADDR_INSERTION_CONTROL, 8'h81);
		nflip = 0;
		run_and_latch(300);
		chk("counted errors", nflip, 3);
		rreg(ADDR_ERRORS_LEFT_LOW);
		chk("left at end", rv, 8'h00);
		wreg(ADDR_INSERTION_CONTROL, 8'h81);
		run_and_latch(100);
		chk("no recommit", nflip, 3);
		wreg(ADDR_INSERTION_CONTROL, 8'h12);
		nflip = 0;
		run_and_latch(400);
		chk("constant errors", nflip >= 6, 1);
		final_report();
	end
endmodule
